// ### verilog/cic_pkg.sv
/*
  Package for the contact input conditioner: register map, control layout,
  event record, state codes and timing tables.
  Assumes a 25 MHz system clock and a classic Wishbone register bus.
*/
`default_nettype none

package cic_pkg;

  // Clock and derived time bases
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned MS_CYC        = CLK_HZ / MS_PER_S;
  localparam int unsigned SENS_STEP_US  = 10;
  localparam int unsigned SENS_STEP_CYC = (SENS_STEP_US * (CLK_HZ / 1_000_000));

  localparam int unsigned TMR_W  = 24;
  localparam int unsigned FLT_W  = 12;
  localparam logic [TMR_W-1:0] MIN_UNIT_MS = 24'h000064; // 0.1 s per unit

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_MINCLOSE = 8'h04;
  localparam logic [7:0] OFS_MINOPEN  = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_EVTCNT   = 8'h10;

  typedef struct packed {
    logic [4:0] long_idx;
    logic       open_type;
    logic       scan_en;
    logic       min_en;
    logic       class_en;
    logic [2:0] deb_idx;
    logic [1:0] sens;
    logic       block_val;
    logic       block_en;
  } cic_ctrl_t;

  localparam cic_ctrl_t CTRL_RST = 16'h1830;  // 50 ms debounce, 0.6 s long press
  localparam logic [15:0] MIN_RST = 16'h000a;

  // Event sources
  localparam logic [1:0] SRC_INPUT = 2'h0;
  localparam logic [1:0] SRC_SCAN  = 2'h1;
  localparam logic [1:0] SRC_MAN   = 2'h2;
  localparam logic [1:0] SRC_CYC   = 2'h3;

  typedef struct packed {
    logic [1:0] src;
    logic       obj;    // 0 main or short object, 1 long object
    logic       value;  // Event 0 or event 1
  } cic_evt_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_DEB   = 4'h2,
    ST_MIN   = 4'h4,
    ST_PRESS = 4'h8
  } cic_state_t;

  function automatic logic [TMR_W-1:0] deb_ms(input logic [2:0] idx);
    case (idx)
      3'h0:    deb_ms = 24'h00000a;
      3'h1:    deb_ms = 24'h000014;
      3'h2:    deb_ms = 24'h00001e;
      3'h3:    deb_ms = 24'h000032;
      3'h4:    deb_ms = 24'h000046;
      3'h5:    deb_ms = 24'h000064;
      default: deb_ms = 24'h000096;
    endcase
  endfunction

  function automatic logic [TMR_W-1:0] long_ms(input logic [4:0] idx);
    case (idx)
      5'h00:   long_ms = 24'h00012c;
      5'h01:   long_ms = 24'h000190;
      5'h02:   long_ms = 24'h0001f4;
      5'h03:   long_ms = 24'h000258;
      5'h04:   long_ms = 24'h000320;
      5'h05:   long_ms = 24'h0003e8;
      5'h06:   long_ms = 24'h0004b0;
      5'h07:   long_ms = 24'h0005dc;
      5'h08:   long_ms = 24'h0007d0;
      5'h09:   long_ms = 24'h000bb8;
      5'h0a:   long_ms = 24'h000fa0;
      5'h0b:   long_ms = 24'h001388;
      5'h0c:   long_ms = 24'h001770;
      5'h0d:   long_ms = 24'h001b58;
      5'h0e:   long_ms = 24'h001f40;
      5'h0f:   long_ms = 24'h002328;
      default: long_ms = 24'h002710;
    endcase
  endfunction

endpackage

`default_nettype wire

// ### verilog/cic_ms_tick.sv
/*
  Millisecond tick generator: one-cycle pulse every DIV clocks.
  Assumes a free running clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none

module cic_ms_tick #(
  parameter int unsigned DIV = 25000
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  output logic      tick
);

  logic [15:0] cnt_reg;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 16'h0000;
      tick    <= 1'b0;
    end else if (cnt_reg == 16'(DIV - 1)) begin
      cnt_reg <= 16'h0000;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick    <= 1'b0;
    end
  end

endmodule // cic_ms_tick

`default_nettype wire

// ### verilog/cic_top.sv
/*
  Contact input conditioner: block, sensitivity filter, debounce,
  short/long classification, minimum signal time and scan after restart,
  with a classic Wishbone register slave.
  Assumes contact_pin is asynchronous; manual, cyclic and scan requests
  come from logic on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module cic_top #(
  parameter int unsigned TICK_DIV = cic_pkg::MS_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        contact_pin,
  input  wire logic        manual_req,
  input  wire logic        manual_val,
  input  wire logic        cyclic_req,
  input  wire logic        scan_req,
  output logic             evt_valid_o,
  output cic_pkg::cic_evt_t evt_o
);

  localparam int unsigned FLT_W = cic_pkg::FLT_W;

  cic_pkg::cic_ctrl_t  ctrl_reg;
  logic [15:0]         min_close_reg;
  logic [15:0]         min_open_reg;
  logic [15:0]         evt_cnt_reg;
  logic                sync1_reg;
  logic                sync2_reg;
  logic                flt_lvl_reg;
  logic [cic_pkg::FLT_W-1:0] flt_cnt_reg;
  cic_pkg::cic_state_t state_reg;
  cic_pkg::cic_state_t state_next;
  logic                app_lvl_reg;
  logic                app_next;
  logic [cic_pkg::TMR_W-1:0] tmr_reg;
  logic [cic_pkg::TMR_W-1:0] tmr_next;
  logic                long_reg;
  logic                long_next;
  logic                man_pend_reg;
  logic                man_val_reg;
  logic                cyc_pend_reg;
  logic                scan_pend_reg;
  logic                scan_take;
  logic                in_fire;
  cic_pkg::cic_evt_t   in_evt;
  logic                tick;
  logic                blocked;
  logic                edge_seen;
  logic                req;
  logic [7:0]          adr;
  logic [31:0]         rd_mux;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        old[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = old;
  endfunction

  function automatic logic [cic_pkg::TMR_W-1:0] min_time(input logic [15:0] v);
    logic [cic_pkg::TMR_W-1:0] u;
    u = (v == 16'h0000) ? 24'h000001 : {8'h00, v};
    min_time = 24'(u * cic_pkg::MIN_UNIT_MS);
  endfunction

  cic_ms_tick #(.DIV(TICK_DIV)) u_tick (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .tick    (tick)
  );

  // Wishbone slave: ack one cycle after the request, write on the ack edge
  assign req = wb_cyc_i & wb_stb_i;
  assign adr = {wb_adr_i[7:2], 2'b00};

  always_comb begin
    unique case (adr)
      cic_pkg::OFS_CTRL:     rd_mux = {16'h0000, ctrl_reg};
      cic_pkg::OFS_MINCLOSE: rd_mux = {16'h0000, min_close_reg};
      cic_pkg::OFS_MINOPEN:  rd_mux = {16'h0000, min_open_reg};
      cic_pkg::OFS_STATUS:   rd_mux = {24'h000000, state_reg, blocked, scan_pend_reg,
                                       app_lvl_reg, flt_lvl_reg};
      cic_pkg::OFS_EVTCNT:   rd_mux = {16'h0000, evt_cnt_reg};
      default:               rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req && !wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg      <= cic_pkg::CTRL_RST;
      min_close_reg <= cic_pkg::MIN_RST;
      min_open_reg  <= cic_pkg::MIN_RST;
    end else if (req && wb_we_i && wb_ack_o) begin
      unique case (adr)
        cic_pkg::OFS_CTRL:     ctrl_reg <= 16'(merge({16'h0000, ctrl_reg}, wb_dat_i, wb_sel_i));
        cic_pkg::OFS_MINCLOSE: min_close_reg <= 16'(merge({16'h0000, min_close_reg}, wb_dat_i,
                                                          wb_sel_i));
        cic_pkg::OFS_MINOPEN:  min_open_reg <= 16'(merge({16'h0000, min_open_reg}, wb_dat_i,
                                                         wb_sel_i));
        default: ;
      endcase
    end
  end

  // Contact pin synchroniser and capacitance-dependent stability filter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= contact_pin;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      flt_lvl_reg <= 1'b0;
      flt_cnt_reg <= '0;
    end else if (sync2_reg == flt_lvl_reg) begin
      flt_cnt_reg <= '0;
    end else if (flt_cnt_reg >= FLT_W'((cic_pkg::SENS_STEP_CYC << ctrl_reg.sens) - 1)) begin
      flt_lvl_reg <= sync2_reg;
      flt_cnt_reg <= '0;
    end else begin
      flt_cnt_reg <= flt_cnt_reg + 1'b1;
    end
  end

  assign blocked   = ctrl_reg.block_en & ctrl_reg.block_val;
  assign edge_seen = ~blocked & (flt_lvl_reg != app_lvl_reg);

  // Input state machine
  always_comb begin
    state_next = state_reg;
    app_next   = app_lvl_reg;
    long_next  = long_reg;
    tmr_next   = (tick && tmr_reg != '0) ? tmr_reg - 1'b1 : tmr_reg;
    in_fire    = 1'b0;
    in_evt     = '{src: cic_pkg::SRC_INPUT, obj: 1'b0, value: flt_lvl_reg};
    scan_take  = 1'b0;
    unique case (state_reg)
      cic_pkg::ST_IDLE: begin
        if (edge_seen) begin
          app_next = flt_lvl_reg;
          if (ctrl_reg.min_en) begin
            tmr_next   = min_time(flt_lvl_reg ? min_close_reg : min_open_reg);
            state_next = cic_pkg::ST_MIN;
          end else if (ctrl_reg.class_en && (flt_lvl_reg ^ ctrl_reg.open_type)) begin
            tmr_next   = '0;
            long_next  = 1'b0;
            state_next = cic_pkg::ST_PRESS;
          end else begin
            in_fire    = ~ctrl_reg.class_en;
            tmr_next   = cic_pkg::deb_ms(ctrl_reg.deb_idx);
            state_next = cic_pkg::ST_DEB;
          end
        end else if (scan_pend_reg && !blocked) begin
          app_next  = flt_lvl_reg;
          in_fire   = ~ctrl_reg.class_en;
          in_evt.src = cic_pkg::SRC_SCAN;
          scan_take = 1'b1;
        end
      end
      cic_pkg::ST_DEB: begin
        if (tmr_reg == '0) begin
          state_next = cic_pkg::ST_IDLE;
        end
      end
      cic_pkg::ST_MIN: begin
        if (edge_seen) begin
          app_next = flt_lvl_reg;
          tmr_next = min_time(flt_lvl_reg ? min_close_reg : min_open_reg);
        end else if (tmr_reg == '0) begin
          in_fire      = 1'b1;
          in_evt.value = app_lvl_reg;
          state_next   = cic_pkg::ST_IDLE;
        end
      end
      cic_pkg::ST_PRESS: begin
        tmr_next = (tick && !long_reg) ? tmr_reg + 1'b1 : tmr_reg;
        if (edge_seen && tmr_reg >= cic_pkg::deb_ms(ctrl_reg.deb_idx)) begin
          app_next   = flt_lvl_reg;
          in_fire    = ~long_reg;
          in_evt     = '{src: cic_pkg::SRC_INPUT, obj: 1'b0, value: 1'b0};
          tmr_next   = cic_pkg::deb_ms(ctrl_reg.deb_idx);
          state_next = cic_pkg::ST_DEB;
        end else if (!long_reg && tmr_reg >= cic_pkg::long_ms(ctrl_reg.long_idx)) begin
          in_fire   = 1'b1;
          in_evt    = '{src: cic_pkg::SRC_INPUT, obj: 1'b1, value: 1'b1};
          long_next = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg   <= cic_pkg::ST_IDLE;
      app_lvl_reg <= 1'b0;
      tmr_reg     <= '0;
      long_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      app_lvl_reg <= app_next;
      tmr_reg     <= tmr_next;
      long_reg    <= long_next;
    end
  end

  // Pending requests: a new request wins over the clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      man_pend_reg  <= 1'b0;
      man_val_reg   <= 1'b0;
      cyc_pend_reg  <= 1'b0;
      scan_pend_reg <= 1'b0;
    end else begin
      if (manual_req) begin
        man_pend_reg <= 1'b1;
        man_val_reg  <= manual_val;
      end else if (!in_fire) begin
        man_pend_reg <= 1'b0;
      end
      if (cyclic_req) begin
        cyc_pend_reg <= 1'b1;
      end else if (!in_fire && !man_pend_reg) begin
        cyc_pend_reg <= 1'b0;
      end
      if (scan_req && ctrl_reg.scan_en) begin
        scan_pend_reg <= 1'b1;
      end else if (scan_take) begin
        scan_pend_reg <= 1'b0;
      end
    end
  end

  // Event output: input first, then manual, then cyclic
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_valid_o <= 1'b0;
      evt_o       <= '0;
      evt_cnt_reg <= 16'h0000;
    end else begin
      evt_valid_o <= in_fire | man_pend_reg | cyc_pend_reg;
      if (in_fire) begin
        evt_o <= in_evt;
      end else if (man_pend_reg) begin
        evt_o <= '{src: cic_pkg::SRC_MAN, obj: 1'b0, value: man_val_reg};
      end else if (cyc_pend_reg) begin
        evt_o <= '{src: cic_pkg::SRC_CYC, obj: 1'b0, value: app_lvl_reg};
      end
      if (evt_valid_o) begin
        evt_cnt_reg <= evt_cnt_reg + 16'h0001;
      end
    end
  end

  a_block_cut: assert property (@(posedge ref_clk) disable iff (!arst_n)
    blocked |=> $stable(app_lvl_reg))
    else $error("Blocked input reached the application");

  a_block_cyclic: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cyc_pend_reg && !in_fire && !man_pend_reg |=> evt_valid_o && evt_o.src == cic_pkg::SRC_CYC)
    else $error("Cyclic resend lost");

  a_manual_free: assert property (@(posedge ref_clk) disable iff (!arst_n)
    man_pend_reg && !in_fire |=> evt_valid_o && evt_o.src == cic_pkg::SRC_MAN)
    else $error("Manual event lost");

  a_edge_react: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state_reg == cic_pkg::ST_IDLE && edge_seen && !ctrl_reg.min_en && !ctrl_reg.class_en
    |=> evt_valid_o && evt_o.value == $past(flt_lvl_reg) && state_reg == cic_pkg::ST_DEB)
    else $error("Edge did not react at once");

  a_deb_ignore: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state_reg == cic_pkg::ST_DEB && tmr_reg != '0
    |=> state_reg == cic_pkg::ST_DEB && $stable(app_lvl_reg))
    else $error("Input evaluated during debounce");

  a_min_quiet: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state_reg == cic_pkg::ST_IDLE && edge_seen && ctrl_reg.min_en
    |=> !(evt_valid_o && evt_o.src == cic_pkg::SRC_INPUT))
    else $error("Telegram sent at min-time start");

  a_min_restart: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state_reg == cic_pkg::ST_MIN && edge_seen
    |=> state_reg == cic_pkg::ST_MIN && app_lvl_reg == $past(flt_lvl_reg) && tmr_reg != '0)
    else $error("Min time not restarted");

  a_min_fire: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state_reg == cic_pkg::ST_MIN && !edge_seen && tmr_reg == '0
    |=> evt_valid_o && evt_o.src == cic_pkg::SRC_INPUT && state_reg == cic_pkg::ST_IDLE)
    else $error("Min time expiry sent nothing");

  a_long_event: assert property (@(posedge ref_clk) disable iff (!arst_n)
    state_reg == cic_pkg::ST_PRESS && !long_reg && !edge_seen
    && tmr_reg >= cic_pkg::long_ms(ctrl_reg.long_idx)
    |=> evt_valid_o && evt_o.obj && evt_o.value && long_reg)
    else $error("Long press not reported");

endmodule // cic_top

`default_nettype wire

// ### tb/cic_contact_model.sv
/*
  Mechanical switch contact model: moves the contact with a short burst of
  bounce that ends on the new level, then holds it.
  Assumes closed contact reads high and that the bench starts each move.
*/
`timescale 1ns/10ps
`default_nettype none

module cic_contact_model (
  input  wire logic ref_clk,
  output var  logic contact_pin
);
  initial contact_pin = 1'b0;

  // Bounce pulses are far shorter than the input filter
  task automatic move(input logic lvl, input int hold);
    repeat (3) begin
      @(posedge ref_clk);
      contact_pin <= lvl;
      repeat (20) @(posedge ref_clk);
      contact_pin <= ~lvl;
    end
    @(posedge ref_clk);
    contact_pin <= lvl;
    repeat (hold) @(posedge ref_clk);
  endtask
endmodule // cic_contact_model

`default_nettype wire

// ### tb/tb_contact_input_conditioner.sv
/*
  Self-checking bench for the contact input conditioner.
  Assumes the tick divider is shortened to 10 clocks, so 1 ms is 10 cycles.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_contact_input_conditioner;
  logic              ref_clk;
  logic              arst_n;
  logic              wb_cyc_i;
  logic              wb_stb_i;
  logic              wb_we_i;
  logic [7:0]        wb_adr_i;
  logic [31:0]       wb_dat_i;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic              contact_pin;
  logic [2:0]        reqs;
  logic              manual_val;
  logic              evt_valid_o;
  cic_pkg::cic_evt_t evt_o;
  cic_pkg::cic_evt_t evq[$];
  logic [31:0]       rd;
  int                err_count;
  int                checked;
  int                n_evt;

  cic_top #(.TICK_DIV(10)) i_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .contact_pin(contact_pin),
    .manual_req(reqs[0]), .manual_val(manual_val), .cyclic_req(reqs[1]),
    .scan_req(reqs[2]), .evt_valid_o(evt_valid_o), .evt_o(evt_o)
  );

  cic_contact_model i_sw (.ref_clk(ref_clk), .contact_pin(contact_pin));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (evt_valid_o === 1'b1) begin
      evq.push_back(evt_o);
      n_evt++;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results;
    if (err_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n >= 50) check("bus ack", 32'h0, 32'h1);
  endtask

  task automatic pulse(input int k);
    @(posedge ref_clk);
    reqs[k] <= 1'b1;
    @(posedge ref_clk);
    reqs <= 3'h0;
    repeat (5) @(posedge ref_clk);
  endtask

  task automatic exp_evt(input string nm, input logic [3:0] e);
    int n;
    n = 0;
    while (evq.size() == 0 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    if (evq.size() == 0) check(nm, 32'hffffffff, {28'h0, e});
    else check(nm, {28'h0, evq.pop_front()}, {28'h0, e});
  endtask

  task automatic exp_none(input string nm);
    check(nm, evq.size(), 32'h0);
  endtask

  task automatic do_reset;
    arst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
  endtask

  initial begin
    #2_000_000;
    err_count++;
    results;
  end

  initial begin
    arst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    reqs = 3'h0;
    manual_val = 1'b1;
    err_count = 0;
    checked = 0;
    n_evt = 0;
    do_reset;
    wb(1'b0, cic_pkg::OFS_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h1830);
    wb(1'b0, cic_pkg::OFS_MINOPEN, 32'h0);
    check("min open reset", rd, 32'h000a);
    wb(1'b1, 8'h14, 32'h1234);
    wb(1'b0, 8'h14, 32'h0);
    check("unmapped", rd, 32'h0);
    // Plain mode, 10 ms debounce
    wb(1'b1, cic_pkg::OFS_CTRL, 32'h0000);
    i_sw.move(1'b1, 400);
    exp_evt("close evt", 4'h1);
    i_sw.move(1'b0, 400);
    exp_evt("open evt", 4'h0);
    // 150 ms debounce hides a reopen inside it
    wb(1'b1, cic_pkg::OFS_CTRL, 32'h0060);
    i_sw.move(1'b1, 500);
    i_sw.move(1'b0, 400);
    i_sw.move(1'b1, 1200);
    exp_evt("deb first", 4'h1);
    exp_none("deb ignore");
    i_sw.move(1'b0, 2000);
    exp_evt("deb after", 4'h0);
    // Highest sensitivity rejects a 1000 cycle pulse, standard does not
    wb(1'b1, cic_pkg::OFS_CTRL, 32'h000c);
    i_sw.move(1'b1, 1000);
    i_sw.move(1'b0, 2500);
    exp_none("sens slow");
    wb(1'b1, cic_pkg::OFS_CTRL, 32'h0000);
    i_sw.move(1'b1, 600);
    i_sw.move(1'b0, 600);
    exp_evt("sens std 1", 4'h1);
    exp_evt("sens std 0", 4'h0);
    // Block cuts the terminal, manual and cyclic still go out
    wb(1'b1, cic_pkg::OFS_CTRL, 32'h0001);
    wb(1'b0, cic_pkg::OFS_STATUS, 32'h0);
    check("unblocked", rd & 32'h8, 32'h0);
    wb(1'b1, cic_pkg::OFS_CTRL, 32'h0003);
    wb(1'b0, cic_pkg::OFS_STATUS, 32'h0);
    check("blocked", rd & 32'h8, 32'h8);
    i_sw.move(1'b1, 600);
    exp_none("blocked pin");
    pulse(0);
    exp_evt("manual", 4'h9);
    pulse(1);
    exp_evt("cyclic", 4'hc);
    i_sw.move(1'b0, 600);
    wb(1'b1, cic_pkg::OFS_CTRL, 32'h0000);
    exp_none("unblock");
    // Short and long press, 0.3 s threshold
    wb(1'b1, cic_pkg::OFS_CTRL, 32'h0080);
    i_sw.move(1'b1, 1000);
    exp_none("press wait");
    i_sw.move(1'b0, 400);
    exp_evt("short", 4'h0);
    i_sw.move(1'b1, 2400);
    exp_none("below long");
    exp_evt("long", 4'h3);
    i_sw.move(1'b0, 600);
    exp_none("long release");
    // Contact that opens on actuation
    wb(1'b1, cic_pkg::OFS_CTRL, 32'h0000);
    i_sw.move(1'b1, 400);
    exp_evt("prep close", 4'h1);
    wb(1'b1, cic_pkg::OFS_CTRL, 32'h0480);
    i_sw.move(1'b0, 1000);
    exp_none("open press");
    i_sw.move(1'b1, 400);
    exp_evt("open short", 4'h0);
    // Minimum signal time, 0.1 s closing and 0.2 s opening
    wb(1'b1, cic_pkg::OFS_MINCLOSE, 32'h1);
    wb(1'b1, cic_pkg::OFS_MINOPEN, 32'h2);
    wb(1'b1, cic_pkg::OFS_CTRL, 32'h0100);
    i_sw.move(1'b0, 600);
    exp_none("min start");
    i_sw.move(1'b1, 300);
    i_sw.move(1'b0, 1600);
    exp_none("min restart");
    exp_evt("min expiry", 4'h0);
    // Scan on request only when enabled
    wb(1'b1, cic_pkg::OFS_CTRL, 32'h0200);
    i_sw.move(1'b1, 400);
    exp_evt("scan prep", 4'h1);
    pulse(2);
    exp_evt("scan on", 4'h5);
    wb(1'b1, cic_pkg::OFS_CTRL, 32'h0000);
    pulse(2);
    exp_none("scan off");
    wb(1'b0, cic_pkg::OFS_EVTCNT, 32'h0);
    check("evt count", rd, {16'h0, n_evt[15:0]});
    // Second reset clears the event counter and restores the control register
    i_sw.move(1'b0, 400);
    exp_evt("last open", 4'h0);
    do_reset;
    wb(1'b0, cic_pkg::OFS_EVTCNT, 32'h0);
    check("cnt after rst", rd, 32'h0);
    wb(1'b0, cic_pkg::OFS_CTRL, 32'h0);
    check("ctrl after rst", rd, 32'h1830);
    results;
  end
endmodule // tb_contact_input_conditioner

`default_nettype wire
